// File: src/irs_params.svh
// register offsets, field positions, reset values and bus constants of the i2c register block
`ifndef IRS_PARAMS_SVH
`define IRS_PARAMS_SVH
// absolute word addresses
`define IRS_ADR_OWN   16'h1a00
`define IRS_ADR_MASK  16'h1a04
`define IRS_ADR_STAT  16'h1a08
`define IRS_ADR_CLKL  16'h1a0c
`define IRS_ADR_CLKH  16'h1a10
`define IRS_ADR_CNT   16'h1a14
`define IRS_ADR_RXD   16'h1a18
`define IRS_ADR_SAR   16'h1a1c
`define IRS_ADR_TXD   16'h1a20
`define IRS_ADR_MODE  16'h1a24
`define IRS_ADR_VEC   16'h1a28
`define IRS_ADR_EMDR  16'h1a2c
`define IRS_ADR_PSC   16'h1a30
`define IRS_ADR_PID1  16'h1a34
`define IRS_ADR_PID2  16'h1a38
// status bit positions
`define IRS_ST_TDIR   14
`define IRS_ST_NSNT   13
`define IRS_ST_BB     12
`define IRS_ST_OVR    11
`define IRS_ST_TX_NO_UNDERFLOW   10
`define IRS_ST_AAS    9
`define IRS_ST_GC     8
`define IRS_ST_SCD    5
`define IRS_ST_XRDY   4
`define IRS_ST_RRDY   3
`define IRS_ST_REGS_READY_FLAG   2
`define IRS_ST_NACK   1
`define IRS_ST_AL     0
`define IRS_STAT_RST  16'h0410
`define IRS_STAT_MASK 16'h7f3f
`define IRS_W1C_MASK  16'h703f
// mode control bit positions
`define IRS_MD_NACKM  15
`define IRS_MD_START  13
`define IRS_MD_STOP   11
`define IRS_MD_CTL    10
`define IRS_MD_XA     8
`define IRS_MD_DLB    6
`define IRS_MD_RUN    5
`define IRS_MD_FDF    3
// field widths, reset values and line constants
`define IRS_OWN_W     10
`define IRS_MASK_W    7
`define IRS_SAR_RST   16'h03ff
`define IRS_SAR_IDX   3
`define IRS_PLAIN_N   6
`define IRS_BUF_N     2
`define IRS_TEN_PFX   5'h1e
`define IRS_LAST_BIT  3'h7
`endif

// File: src/irs_pkg.sv
// types shared by the i2c register block
`include "irs_params.svh"
package irs_pkg;
   // target-side line sequencer states
   typedef enum logic [2:0] {
      IRS_IDLE,
      IRS_ADDR,
      IRS_ADDR2,
      IRS_RX,
      IRS_ACK,
      IRS_TX,
      IRS_TACK
   } irs_fsm_t;

   // one register access from the cpu or dma side
   typedef struct packed {
      logic        rd;      // read strobe
      logic        wr;      // write strobe
      logic [15:0] addr;    // absolute word address
      logic [15:0] wdata;   // write data
   } irs_req_t;

   // whole state of the block
   typedef struct packed {
      logic [2:0]                        scl_sy;  // sync chain plus previous sample
      logic [2:0]                        sda_sy;  // sync chain plus previous sample
      irs_fsm_t                          st;      // sequencer state
      irs_fsm_t                          after;   // state after our ack slot
      logic                              ph;      // ack slot phase
      logic                              ack;     // ack decision
      logic [2:0]                        cnt;     // bit counter
      logic [7:0]                        sh;      // receive shift register
      logic [7:0]                        tsh;     // transmit shift register
      logic [`IRS_OWN_W-1:0]             own;     // own target address
      logic [`IRS_MASK_W-1:0]            mask;    // interrupt enables
      logic [15:0]                       mode;    // mode control
      logic [15:0]                       flags;   // status flags
      logic [`IRS_PLAIN_N-1:0][15:0]     plain;   // storage-only registers
      logic [7:0]                        txd;     // transmit data register
      logic                              txf;     // new transmit data present
      logic [`IRS_BUF_N-1:0][7:0]        buff;    // receive buffer entries
      logic                              wp;      // buffer write index
      logic                              rp;      // buffer read index
      logic [1:0]                        fill;    // buffer occupancy
      logic [7:0]                        pend;    // byte held back on overrun
      logic                              pendv;   // held byte valid
      logic [15:0]                       rdata;   // read data
      logic                              irq;     // interrupt request
      logic                              sda_oe;  // pull sda low
   } irs_state_t;
endpackage

// File: src/irs_top.sv
// i2c register, status and target-side line block
//
// Functional notes
// - registers at fixed 16-bit word addresses
// - seven-bit mode compares own bits 6-0
// - ten-bit mode uses own bits 9-0
// - reserved own, mask and status bits read zero, ignore writes; mode stores all 16 bits
// - mask holds one enable per event
// - status resets to 410h
// - direction bit set as target transmitter
// - nack-sent flag set on our nack
// - bus busy tracks start and stop
// - overrun holds byte, flags it
// - no-underflow clears on empty transmit
// - addressed-as-target on address match
// - general call on all-zero address in seven-bit mode
// - stop seen on any stop
// - vector read clears named flag for loss, nack and stop codes only
// - request needs flag and enable
// - transmit ready cleared by data write
// - receive ready cleared by read
// - arbitration loss drops controller mode
`timescale 1ns/1ps
`include "irs_params.svh"
module irs_top #(
   parameter int IDENT1 = 32'h0000_1234,  // arbitrary identification value
   parameter int IDENT2 = 32'h0000_0001   // arbitrary identification value
) (
   input  wire logic              clk_sys,    // module clock
   input  wire logic              rst_n,      // asynchronous reset, active low
   input  wire irs_pkg::irs_req_t req,        // register access
   output logic [15:0]            rdata,      // read data, one cycle after rd
   input  wire logic              periph_rst, // peripheral reset from system
   input  wire logic              scl_i,      // scl pin level
   input  wire logic              sda_i,      // sda pin level
   output logic                   sda_o,      // sda drive level, always low
   output logic                   sda_oe,     // high while pulling sda low
   output logic                   int_req     // interrupt request level
);
   // identification values must fit the 16-bit word
   if (IDENT1 < 0 || IDENT1 > 32'h0000_ffff || IDENT2 < 0 || IDENT2 > 32'h0000_ffff) begin
      $error("identification parameter exceeds 16 bits");
   end

   // addresses of the storage-only registers, by index
   localparam logic [`IRS_PLAIN_N-1:0][15:0] PLAIN_ADR = {
      `IRS_ADR_PSC, `IRS_ADR_EMDR, `IRS_ADR_SAR,
      `IRS_ADR_CNT, `IRS_ADR_CLKH, `IRS_ADR_CLKL};

   irs_pkg::irs_state_t s;      // registered state
   irs_pkg::irs_state_t s_nxt;  // next state

   logic scl, sclp, sda, sdap;  // synchronised and previous line levels
   logic rise, fall;            // scl edges
   logic evt_start, evt_stop;   // bus conditions
   logic mreset;                // module held in reset

   // only the second and third stages are read; the first feeds the second alone
   assign scl  = s.scl_sy[1];
   assign sclp = s.scl_sy[2];
   assign sda  = s.sda_sy[1];
   assign sdap = s.sda_sy[2];
   assign rise = scl & ~sclp;
   assign fall = ~scl & sclp;
   // sda moving while scl stays high marks start or stop
   assign evt_start = scl & sclp & sdap & ~sda;
   assign evt_stop  = scl & sclp & ~sdap & sda;
   assign mreset    = ~s.mode[`IRS_MD_RUN] | periph_rst;

   assign rdata   = s.rdata;
   assign sda_o   = 1'b0;   // open drain: only the enable moves
   assign sda_oe  = s.sda_oe;
   assign int_req = s.irq;

   // all next-state logic
   always_comb begin
      logic [15:0] fset;      // flags set by hardware
      logic [15:0] fclr;      // flags cleared by software or line
      logic [7:0]  byte_in;   // byte completed this edge
      logic        newbyte;   // received data byte completed
      logic        pop;       // receive buffer drained
      logic        push;      // receive buffer filled
      logic        space;     // buffer can take a byte
      logic [6:0]  ev;        // event flags in mask order
      logic [2:0]  code;      // vector code
      logic        rd_rx;     // receive data read
      logic        ld_tx;     // transmit shift load
      fset    = 16'h0000;
      fclr    = 16'h0000;
      byte_in = {s.sh[6:0], sda};
      newbyte = 1'b0;
      push    = 1'b0;
      ld_tx   = 1'b0;
      code    = 3'h0;
      s_nxt   = s;
      s_nxt.scl_sy = {s.scl_sy[1:0], scl_i};
      s_nxt.sda_sy = {s.sda_sy[1:0], sda_i};
      rd_rx = req.rd & (req.addr == `IRS_ADR_RXD);

      // vector: lowest code among pending enabled events wins
      ev = {s.flags[`IRS_ST_AAS], s.flags[`IRS_ST_SCD:0]};
      for (int i = 6; i >= 0; i--) begin
         if (ev[i] & s.mask[i]) begin
            code = 3'(i + 1);
         end
      end

      // register writes
      if (req.wr) begin
         case (req.addr)
            `IRS_ADR_OWN: begin
               s_nxt.own = req.wdata[`IRS_OWN_W-1:0];
            end
            `IRS_ADR_MASK: begin
               s_nxt.mask = req.wdata[`IRS_MASK_W-1:0];
            end
            `IRS_ADR_STAT: begin
               // zeros written leave flags alone so read-back writes are safe
               fclr = req.wdata & `IRS_W1C_MASK;
            end
            `IRS_ADR_TXD: begin
               s_nxt.txd = req.wdata[7:0];
               s_nxt.txf = 1'b1;
               fclr[`IRS_ST_XRDY] = 1'b1;
               fset[`IRS_ST_TX_NO_UNDERFLOW] = 1'b1;
            end
            `IRS_ADR_MODE: begin
               s_nxt.mode = req.wdata;
               // starting as controller on a busy bus loses arbitration
               if (req.wdata[`IRS_MD_START] & req.wdata[`IRS_MD_CTL]
                   & s.flags[`IRS_ST_BB]) begin
                  fset[`IRS_ST_AL] = 1'b1;
                  s_nxt.mode[`IRS_MD_CTL]  = 1'b0;
                  s_nxt.mode[`IRS_MD_STOP] = 1'b0;
               end
            end
            default: begin
               for (int i = 0; i < `IRS_PLAIN_N; i++) begin
                  if (req.addr == PLAIN_ADR[i]) begin
                     s_nxt.plain[i] = req.wdata;
                  end
               end
            end
         endcase
      end

      // register reads, answered one cycle later
      if (req.rd) begin
         s_nxt.rdata = 16'h0000;  // unlisted offsets read zero
         case (req.addr)
            `IRS_ADR_OWN:  s_nxt.rdata = {6'h00, s.own};
            `IRS_ADR_MASK: s_nxt.rdata = {9'h000, s.mask};
            `IRS_ADR_STAT: s_nxt.rdata = s.flags & `IRS_STAT_MASK;
            `IRS_ADR_RXD:  s_nxt.rdata = {8'h00, s.buff[s.rp]};
            `IRS_ADR_TXD:  s_nxt.rdata = {8'h00, s.txd};
            `IRS_ADR_MODE: s_nxt.rdata = s.mode;
            `IRS_ADR_PID1: s_nxt.rdata = IDENT1[15:0];
            `IRS_ADR_PID2: s_nxt.rdata = IDENT2[15:0];
            `IRS_ADR_VEC: begin
               s_nxt.rdata = {13'h0000, code};
               // ready and addressed flags survive a vector read
               case (code)
                  3'h1:    fclr[`IRS_ST_AL]   = 1'b1;
                  3'h2:    fclr[`IRS_ST_NACK] = 1'b1;
                  3'h6:    fclr[`IRS_ST_SCD]  = 1'b1;
                  default: ;
               endcase
            end
            default: begin
               for (int i = 0; i < `IRS_PLAIN_N; i++) begin
                  if (req.addr == PLAIN_ADR[i]) begin
                     s_nxt.rdata = s.plain[i];
                  end
               end
            end
         endcase
      end

      // line sequencer
      if (evt_stop) begin
         fset[`IRS_ST_SCD] = 1'b1;
         fclr[`IRS_ST_BB]  = 1'b1;
         fclr[`IRS_ST_AAS] = 1'b1;
         fclr[`IRS_ST_GC]  = 1'b1;
         // loopback leaves the direction bit to software
         fclr[`IRS_ST_TDIR] = ~s.mode[`IRS_MD_DLB];
         if (s.mode[`IRS_MD_CTL]) begin
            fset[`IRS_ST_REGS_READY_FLAG] = 1'b1;
         end
         s_nxt.st = irs_pkg::IRS_IDLE;
      end else if (evt_start) begin
         fset[`IRS_ST_BB]   = 1'b1;
         fclr[`IRS_ST_AAS]  = 1'b1;
         fclr[`IRS_ST_GC]   = 1'b1;
         fclr[`IRS_ST_TDIR] = ~s.mode[`IRS_MD_DLB];
         s_nxt.st  = s.mode[`IRS_MD_FDF] ? irs_pkg::IRS_RX : irs_pkg::IRS_ADDR;
         s_nxt.cnt = 3'h0;
      end else begin
         case (s.st)
            irs_pkg::IRS_ADDR, irs_pkg::IRS_ADDR2, irs_pkg::IRS_RX: begin
               if (rise) begin
                  s_nxt.sh  = byte_in;
                  s_nxt.cnt = s.cnt + 3'h1;
                  if (s.cnt == `IRS_LAST_BIT) begin
                     // default: no match, drop off the bus
                     s_nxt.st    = irs_pkg::IRS_IDLE;
                     s_nxt.ph    = 1'b0;
                     s_nxt.ack   = 1'b1;
                     s_nxt.after = irs_pkg::IRS_RX;
                     if (s.st == irs_pkg::IRS_RX) begin
                        newbyte  = 1'b1;
                        s_nxt.st = irs_pkg::IRS_ACK;
                        if (s.mode[`IRS_MD_FDF]) begin
                           fset[`IRS_ST_AAS] = 1'b1;
                        end
                        if (s.mode[`IRS_MD_NACKM]) begin
                           s_nxt.ack = 1'b0;
                           s_nxt.mode[`IRS_MD_NACKM] = 1'b0;
                           fset[`IRS_ST_NSNT] = 1'b1;
                        end
                     end else if (s.st == irs_pkg::IRS_ADDR2) begin
                        if (byte_in == s.own[7:0]) begin
                           fset[`IRS_ST_AAS] = 1'b1;
                           s_nxt.st = irs_pkg::IRS_ACK;
                        end
                     end else if (s.mode[`IRS_MD_XA]) begin
                        // ten-bit header: prefix plus own bits 9-8
                        if (byte_in[7:3] == `IRS_TEN_PFX
                            && byte_in[2:1] == s.own[9:8]) begin
                           if (~byte_in[0]) begin
                              s_nxt.st    = irs_pkg::IRS_ACK;
                              s_nxt.after = irs_pkg::IRS_ADDR2;
                           end else if (s.flags[`IRS_ST_AAS]) begin
                              s_nxt.st    = irs_pkg::IRS_ACK;
                              s_nxt.after = irs_pkg::IRS_TX;
                              fset[`IRS_ST_TDIR] = 1'b1;
                              fset[`IRS_ST_AAS]  = 1'b1;
                           end
                        end
                     end else if (byte_in == 8'h00) begin
                        fset[`IRS_ST_GC]  = 1'b1;
                        fset[`IRS_ST_AAS] = 1'b1;
                        s_nxt.st = irs_pkg::IRS_ACK;
                     end else if (byte_in[7:1] == s.own[6:0]) begin
                        fset[`IRS_ST_AAS] = 1'b1;
                        s_nxt.st = irs_pkg::IRS_ACK;
                        if (byte_in[0]) begin
                           s_nxt.after = irs_pkg::IRS_TX;
                           fset[`IRS_ST_TDIR] = 1'b1;
                        end
                     end
                  end
               end
            end
            irs_pkg::IRS_ACK: begin
               // first fall opens our ack slot, second fall closes it
               if (fall) begin
                  s_nxt.ph = 1'b1;
                  if (s.ph) begin
                     s_nxt.st  = s.after;
                     s_nxt.ph  = 1'b0;
                     s_nxt.cnt = 3'h0;
                     ld_tx     = (s.after == irs_pkg::IRS_TX);
                  end
               end
            end
            irs_pkg::IRS_TX: begin
               if (rise) begin
                  s_nxt.cnt = s.cnt + 3'h1;
                  if (s.cnt == `IRS_LAST_BIT) begin
                     s_nxt.st  = irs_pkg::IRS_TACK;
                     s_nxt.ph  = 1'b0;
                     s_nxt.ack = 1'b0;
                  end
               end else if (fall) begin
                  s_nxt.tsh = {s.tsh[6:0], 1'b1};
               end
            end
            irs_pkg::IRS_TACK: begin
               if (fall) begin
                  s_nxt.ph = 1'b1;
                  if (s.ph & s.ack) begin
                     s_nxt.st  = irs_pkg::IRS_TX;
                     s_nxt.ph  = 1'b0;
                     s_nxt.cnt = 3'h0;
                     ld_tx     = 1'b1;
                  end
               end else if (rise & s.ph) begin
                  // receiver's answer to our byte
                  s_nxt.ack = ~sda;
                  if (sda) begin
                     fset[`IRS_ST_NACK] = 1'b1;
                     s_nxt.st = irs_pkg::IRS_IDLE;
                  end
               end
            end
            default: ;
         endcase
      end

      // copy transmit data into the shifter; stale data is resent
      if (ld_tx) begin
         s_nxt.tsh = s.txd;
         if (s.txf) begin
            s_nxt.txf = 1'b0;
            fset[`IRS_ST_XRDY] = 1'b1;
         end else begin
            fclr[`IRS_ST_TX_NO_UNDERFLOW] = 1'b1;
         end
      end

      // two-entry receive buffer; a read frees room for a held byte
      pop   = rd_rx & (s.fill != 2'h0);
      space = (s.fill != 2'(`IRS_BUF_N)) | pop;
      if (rd_rx) begin
         fclr[`IRS_ST_OVR]  = 1'b1;
         fclr[`IRS_ST_RRDY] = 1'b1;
      end
      if (pop) begin
         s_nxt.rp = ~s.rp;
      end
      if (s.pendv & space) begin
         push = 1'b1;
         s_nxt.buff[s.wp] = s.pend;
         s_nxt.pendv = 1'b0;
      end
      if (newbyte) begin
         if (space & ~push) begin
            push = 1'b1;
            s_nxt.buff[s.wp] = byte_in;
         end else begin
            // no room: hold the byte back, later bytes overwrite it
            s_nxt.pend  = byte_in;
            s_nxt.pendv = 1'b1;
            fset[`IRS_ST_OVR] = 1'b1;
         end
      end
      if (push) begin
         s_nxt.wp = ~s.wp;
      end
      s_nxt.fill = s.fill + 2'(push) - 2'(pop);
      if (push | (pop & (s_nxt.fill != 2'h0))) begin
         fset[`IRS_ST_RRDY] = 1'b1;
      end

      // set beats clear so no event is lost
      s_nxt.flags = ((s.flags & ~fclr) | fset) & `IRS_STAT_MASK;

      // module reset: status back to reset value with busy following scl low, sequencer and buffer empty
      if (mreset) begin
         s_nxt.flags = `IRS_STAT_RST;
         s_nxt.flags[`IRS_ST_BB] = ~scl;
         s_nxt.st    = irs_pkg::IRS_IDLE;
         s_nxt.fill  = 2'h0;
         s_nxt.wp    = 1'b0;
         s_nxt.rp    = 1'b0;
         s_nxt.pendv = 1'b0;
         s_nxt.txf   = 1'b0;
      end

      // line drive and interrupt request from the new state
      s_nxt.sda_oe = (s_nxt.st == irs_pkg::IRS_ACK & s_nxt.ph & s_nxt.ack)
                     | (s_nxt.st == irs_pkg::IRS_TX & ~s_nxt.tsh[7])
                     | (s_nxt.st == irs_pkg::IRS_TACK & ~s_nxt.ph & ~s_nxt.tsh[7]);
      s_nxt.irq = |({s_nxt.flags[`IRS_ST_AAS], s_nxt.flags[`IRS_ST_SCD:0]}
                    & s_nxt.mask);
   end

   // state register; lines idle high after reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.scl_sy <= 3'h7;
         s.sda_sy <= 3'h7;
         s.flags  <= `IRS_STAT_RST;
         s.plain[`IRS_SAR_IDX] <= `IRS_SAR_RST;
      end else begin
         s <= s_nxt;
      end
   end
endmodule

// File: test/irs_chk_props.sv
// port checker for the i2c register block
`timescale 1ns/1ps
`include "irs_params.svh"
module irs_chk_props (
   input wire logic              clk_sys, // module clock
   input wire logic              rst_n,   // async reset, active low
   input wire irs_pkg::irs_req_t req,     // register access
   input wire logic [15:0]       rdata,   // read data
   input wire logic              int_req  // interrupt request
);
   logic [6:0] mask_r; // shadow of the enables
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // shadow copy, so the request can be judged from the ports alone
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mask_r <= 7'h00;
      end else if (req.wr && req.addr == `IRS_ADR_MASK) begin
         mask_r <= req.wdata[6:0];
      end
   end
   sequence rd_at(logic [15:0] a);
      req.rd && req.addr == a;
   endsequence
   a_own_resv_zero: assert property (rd_at(`IRS_ADR_OWN) |=> rdata[15:10] == 6'h00)
      else $error("own address reserved bits set");
   a_mask_read_back: assert property (rd_at(`IRS_ADR_MASK) |=> rdata == {9'h000, $past(mask_r)})
      else $error("enable read back wrong");
   a_stat_resv_zero: assert property (rd_at(`IRS_ADR_STAT) |=> !rdata[15] && rdata[7:6] == 2'h0)
      else $error("status reserved bits set");
   a_hole_reads_zero: assert property (rd_at(16'h1a3c) |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_irq_needs_en: assert property (mask_r == 7'h00 && $past(mask_r) == 7'h00 |-> !int_req)
      else $error("request with all enables off");
   a_txd_clears_rdy: assert property ((req.wr && req.addr == `IRS_ADR_TXD) ##1 rd_at(`IRS_ADR_STAT)
      |=> !rdata[4] && rdata[10])
      else $error("transmit write left ready set");
   a_vec_clears_scd: assert property (rd_at(`IRS_ADR_VEC) ##1 (rdata[2:0] == 3'h6) ##0
      rd_at(`IRS_ADR_STAT) |=> !rdata[5])
      else $error("vector read kept stop flag");
   a_zero_wr_keeps: assert property (rd_at(`IRS_ADR_STAT) ##1 (req.wr && req.wdata == 16'h0000
      && req.addr == `IRS_ADR_STAT) ##1 rd_at(`IRS_ADR_STAT) |=> rdata == $past(rdata, 2))
      else $error("zero write changed status");
endmodule

// File: test/irs_ctl_model.sv
// behavioural i2c controller that clocks frames into the target block
`timescale 1ns/1ps
module irs_ctl_model (
   output logic      scl,   // clock line, stands high outside frames
   output logic      sda_m, // our sda drive, 1 releases to the pull-up
   input  wire logic sda    // resolved sda line
);
   initial begin
      scl   = 1'b1;
      sda_m = 1'b1;
   end
   // start: sda falls while scl is high
   task automatic start();
      sda_m = 1'b0;
      #80 scl = 1'b0;
      #40;
   endtask
   // nine bits msb first, sda only moves while scl is low
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda_m = tx[i];
         #40 scl = 1'b1;
         #40 rx[i] = sda;
         #40 scl = 1'b0;
         #40;
      end
   endtask
   // stop: sda rises while scl is high
   task automatic stop();
      sda_m = 1'b0;
      #40 scl = 1'b1;
      #40 sda_m = 1'b1;
      #80;
   endtask
endmodule

// File: test/tb_top.sv
// self-checking bench of the i2c register block
`timescale 1ns/1ps
`include "irs_params.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t mismatch got %h exp %h", $time, g, e); end end
module tb_top;
   localparam int ID1 = 32'h0000_5a3c; // arbitrary identification value
   localparam int ID2 = 32'h0000_00a5; // arbitrary identification value
   logic clk_sys, rst_n, periph_rst, sda_o, sda_oe, int_req, scl, sda_m;
   wire  sda = sda_m & !(sda_oe && !sda_o); // open drain with pull-up
   irs_pkg::irs_req_t req;
   logic [15:0] rdata, v, q, adr[4], msk[4];
   logic [8:0]  rx;
   logic [9:0]  own;
   logic [7:0]  d[3];
   int          seed, bad_count, samples_checked, i;
   irs_top #(.IDENT1(ID1), .IDENT2(ID2)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
      .rdata(rdata), .periph_rst(periph_rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .int_req(int_req));
   irs_ctl_model m (.scl(scl), .sda_m(sda_m), .sda(sda));
   always #10 clk_sys = ~clk_sys;
   // expected value of each word address just after reset
   function automatic logic [15:0] rst_val(input int k);
      case (k)
         2: return `IRS_STAT_RST;
         7: return `IRS_SAR_RST;
         13: return ID1[15:0];
         14: return ID2[15:0];
         default: return 16'h0000;
      endcase
   endfunction
   task automatic bus(input logic w, r, input logic [15:0] a, dt);
      @(negedge clk_sys);
      req <= '{r, w, a, dt};
   endtask
   task automatic idle();
      @(negedge clk_sys);
      req <= '0;
   endtask
   task automatic wr(input logic [15:0] a, dt);
      bus(1'b1, 1'b0, a, dt);
      idle();
   endtask
   // rdata is taken one cycle after the read strobe
   task automatic rd(input logic [15:0] a, output logic [15:0] q);
      bus(1'b0, 1'b1, a, 16'h0000);
      idle();
      @(negedge clk_sys);
      q = rdata;
   endtask
   task automatic stop_test();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // watchdog, far beyond the roughly 1300 cycles the run needs
   initial begin
      #400_000;
      bad_count++;
      stop_test();
   end
   initial begin
      clk_sys = 0; rst_n = 0; periph_rst = 0; req = '0; seed = 41389;
      adr = '{`IRS_ADR_OWN, `IRS_ADR_MASK, `IRS_ADR_CLKL, `IRS_ADR_PSC};
      msk = '{16'h03ff, 16'h007f, 16'hffff, 16'hffff};
      repeat (5) @(negedge clk_sys);
      rst_n = 1;
      for (i = 0; i < 16; i++) begin
         rd(16'h1a00 + 16'(i * 4), v);
         `CHK(v, rst_val(i))
      end
      for (i = 0; i < 8; i++) begin
         v = 16'($random(seed));
         wr(adr[i % 4], v);
         rd(adr[i % 4], q); // read-back of the masked field
         `CHK(q, v & msk[i % 4])
      end
      // random own address kept clear of general call and the ten-bit header
      own = 10'($random(seed));
      own[6] = 1'b0;
      own[0] = 1'b1;
      wr(`IRS_ADR_MASK, 16'h0000);
      wr(`IRS_ADR_OWN, {6'h00, own});
      wr(`IRS_ADR_MODE, 16'h0020);
      m.start();
      m.xfer({own[6:0], 2'b01}, rx);
      `CHK(rx[0], 1'b0)
      for (i = 0; i < 3; i++) begin
         d[i] = 8'($random(seed));
         m.xfer({d[i], 1'b1}, rx);
         `CHK(rx[0], 1'b0)
      end
      wr(`IRS_ADR_MODE, 16'h2c20);
      rd(`IRS_ADR_MODE, v);
      `CHK(v, 16'h2020)
      wr(`IRS_ADR_MODE, 16'h0020);
      bus(1'b0, 1'b1, `IRS_ADR_STAT, 16'h0000);
      bus(1'b1, 1'b0, `IRS_ADR_STAT, 16'h0000);
      rd(`IRS_ADR_STAT, v);
      `CHK(v, 16'h1e19)
      wr(`IRS_ADR_STAT, 16'h0001);
      for (i = 0; i < 3; i++) begin
         rd(`IRS_ADR_RXD, v);
         `CHK(v, {8'h00, d[i]})
      end
      rd(`IRS_ADR_STAT, v);
      `CHK(v, 16'h1610)
      m.stop();
      repeat (4) @(negedge clk_sys);
      rd(`IRS_ADR_STAT, v);
      `CHK(v, 16'h0430)
      wr(`IRS_ADR_MASK, 16'h0020);
      @(negedge clk_sys);
      `CHK(int_req, 1'b1)
      bus(1'b0, 1'b1, `IRS_ADR_VEC, 16'h0000);
      rd(`IRS_ADR_STAT, v);
      `CHK(v, 16'h0410)
      `CHK(int_req, 1'b0)
      m.start();
      m.xfer(9'h001, rx);
      rd(`IRS_ADR_STAT, v);
      `CHK({rx[0], v}, {1'b0, 16'h1710})
      m.stop();
      repeat (4) @(negedge clk_sys);
      wr(`IRS_ADR_STAT, 16'h0020);
      rd(`IRS_ADR_STAT, v);
      `CHK(v, 16'h0410)
      d[0] = 8'($random(seed));
      bus(1'b1, 1'b0, `IRS_ADR_TXD, {8'h00, d[0]});
      rd(`IRS_ADR_STAT, v);
      `CHK(v, 16'h0400)
      m.start();
      m.xfer({own[6:0], 2'b11}, rx);
      rd(`IRS_ADR_STAT, v);
      `CHK({rx[0], v[14]}, 2'b01)
      m.xfer(9'h1ff, rx);
      `CHK(rx[8:1], d[0])
      m.stop();
      repeat (4) @(negedge clk_sys);
      rd(`IRS_ADR_STAT, v);
      `CHK({v[14], v[5], v[1]}, 3'b011)
      // loopback read: no new data, old byte resent, direction bit survives stop
      wr(`IRS_ADR_MODE, 16'h0060);
      m.start();
      m.xfer({own[6:0], 2'b11}, rx);
      m.xfer(9'h1ff, rx);
      `CHK(rx[8:1], d[0])
      m.stop();
      repeat (4) @(negedge clk_sys);
      rd(`IRS_ADR_STAT, v);
      `CHK({v[14], v[10]}, 2'b10)
      wr(`IRS_ADR_STAT, 16'h4000);
      rd(`IRS_ADR_STAT, v);
      `CHK(v[14], 1'b0)
      // nack mode: next data byte refused, mode bit drops by itself
      wr(`IRS_ADR_MODE, 16'h8020);
      m.start();
      m.xfer({own[6:0], 2'b01}, rx);
      m.xfer({d[1], 1'b1}, rx);
      m.stop();
      rd(`IRS_ADR_MODE, v);
      `CHK({rx[0], v}, {1'b1, 16'h0020})
      rd(`IRS_ADR_STAT, v);
      `CHK(v[13], 1'b1)
      // ten-bit addressing: header with own bits 9-8, then own bits 7-0
      wr(`IRS_ADR_MODE, 16'h0120);
      m.start();
      m.xfer({`IRS_TEN_PFX, own[9:8], 2'b01}, rx);
      `CHK(rx[0], 1'b0)
      m.xfer({own[7:0], 1'b1}, rx);
      rd(`IRS_ADR_STAT, v);
      `CHK({rx[0], v[9]}, 2'b01)
      m.stop();
      // free format: first word addresses us without any address byte
      wr(`IRS_ADR_MODE, 16'h0028);
      m.start();
      m.xfer({d[2], 1'b1}, rx);
      rd(`IRS_ADR_STAT, v);
      `CHK({rx[0], v[9]}, 2'b01)
      m.stop();
      periph_rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      periph_rst = 1'b0;
      rd(`IRS_ADR_STAT, v);
      `CHK(v, 16'h0410)
      stop_test();
   end
endmodule
bind irs_top irs_chk_props u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rdata(rdata),
   .int_req(int_req));
